// ### hdl/psa_regs.vh
`ifndef PSA_REGS_VH
`define PSA_REGS_VH
// Widths
`define PSA_PW_W        24
`define PSA_DW_W        16
`define PSA_PA_W        24
// Address field positions
`define PSA_CFG_BIT     23
`define PSA_PAGE_LSB    16
`define PSA_PAGE_MSB    23
// Remap window in data space
`define PSA_WIN_BASE    16'h8000
`define PSA_WIN_BIT     15
// Reset values
`define PSA_PAGE_RST    8'h00
`define PSA_WIN_PAGE_RST 8'h00
// Access latency in cycles
`define PSA_RD_LAT      1
// Word address width of the program array model
`define PSA_MEM_AW      10
`endif

// ### hdl/psa_mem.v
`timescale 1ns/1ps
`include "psa_regs.vh"
// Program word array; read data is registered
module psa_mem (
  // Clock
  input  wire                    clk_in,
  // Access
  input  wire [`PSA_MEM_AW-1:0]  addr_in,
  input  wire                    wr_in,
  input  wire [2:0]              lane_en_in,
  input  wire [`PSA_PW_W-1:0]    wdata_in,
  output reg  [`PSA_PW_W-1:0]    rdata_out
);
  reg [`PSA_PW_W-1:0] mem_r [0:(1<<`PSA_MEM_AW)-1];
  integer i;

  always @(posedge clk_in) begin
    if (wr_in) begin
      for (i = 0; i < 3; i = i + 1) begin
        if (lane_en_in[i])
          mem_r[addr_in][i*8 +: 8] <= wdata_in[i*8 +: 8];
      end
    end
    rdata_out <= mem_r[addr_in];
  end
endmodule // psa_mem

// ### hdl/psa_top.v
`timescale 1ns/1ps
`include "psa_regs.vh"
// Overview of operation
// RQ1 - Bridge 24-bit program and 16-bit data words
// RQ2 - Keep alignment consistent across both spaces
// RQ3 - Fetch, table access and remap paths
// RQ4 - Table access reaches every program word byte
// RQ5 - Remapped window is read-only
// RQ6 - Remap reads return low 16 bits only
// RQ7 - Fetch address is 0, PC[22:1], 0
// RQ8 - Table address is page and EA
// RQ9 - Page top bit selects configuration space
// RQ10 - EA bit 0 selects byte lane
module psa_top (
  // Clock and reset
  input  wire                   clk_in,
  input  wire                   rst_in,
  // Fetch
  input  wire                   fetch_req_in,
  input  wire [22:0]            pc_in,
  output reg                    fetch_valid_out,
  output reg  [`PSA_PW_W-1:0]   fetch_instr_out,
  // Table access
  input  wire                   table_read_instr_in,
  input  wire                   table_write_instr_in,
  input  wire                   tbl_hi_in,
  input  wire                   tbl_byte_in,
  input  wire [15:0]            tbl_ea_in,
  input  wire [`PSA_DW_W-1:0]   tbl_wdata_in,
  input  wire                   page_wr_in,
  input  wire [7:0]             page_wdata_in,
  output wire [7:0]             table_page_reg_out,
  output reg                    tbl_valid_out,
  output reg  [`PSA_DW_W-1:0]   tbl_rdata_out,
  // Remap window
  input  wire                   win_rd_in,
  input  wire                   win_wr_in,
  input  wire [15:0]            win_ea_in,
  input  wire                   win_page_wr_in,
  input  wire [7:0]             win_page_wdata_in,
  output reg                    win_valid_out,
  output reg  [`PSA_DW_W-1:0]   win_rdata_out,
  output reg                    win_wr_blocked_out,
  // Program address seen by the array and configuration side
  output reg  [`PSA_PA_W-1:0]   prog_addr_out,
  output reg                    cfg_access_out
);
  localparam [3:0] ST_IDLE  = 4'b0001;
  localparam [3:0] ST_FETCH = 4'b0010;
  localparam [3:0] ST_TBL   = 4'b0100;
  localparam [3:0] ST_WIN   = 4'b1000;

  reg [3:0]            state_r;
  reg [3:0]            state_nxt;
  reg [7:0]            table_page_reg_r;
  reg [7:0]            win_page_r;
  reg                  hi_r;
  reg                  byte_r;
  reg                  lane_r;
  reg [`PSA_PA_W-1:0]  addr_nxt;
  reg                  mem_wr;
  reg [2:0]            lane_en;
  reg [`PSA_PW_W-1:0]  mem_wdata;
  wire [`PSA_PW_W-1:0] mem_rdata;
  wire                 win_hit;

  // Table address: page over effective address
  function [`PSA_PA_W-1:0] tbl_addr;
    input [7:0]  page;
    input [15:0] ea;
    begin
      tbl_addr = {page, ea}; // RQ8 RQ9
    end
  endfunction

  // Byte lanes touched by a table write
  function [2:0] wr_lanes;
    input hi;
    input byt;
    input lsb;
    begin
      // Upper byte write in byte mode with odd EA touches no lane
      if (hi)
        wr_lanes = byt ? {~lsb, 2'b00} : 3'b100; // RQ4
      else if (byt)
        wr_lanes = lsb ? 3'b010 : 3'b001; // RQ10
      else
        wr_lanes = 3'b011;
    end
  endfunction

  // Data placed on the lanes of a table write
  function [`PSA_PW_W-1:0] wr_word;
    input                 hi;
    input                 byt;
    input [`PSA_DW_W-1:0] d;
    begin
      if (hi)
        wr_word = {d[7:0], 16'h0000};
      else if (byt)
        wr_word = {8'h00, d[7:0], d[7:0]};
      else
        wr_word = {8'h00, d}; // RQ1
    end
  endfunction

  // Table read result picked out of a program word
  function [`PSA_DW_W-1:0] rd_pick;
    input                 hi;
    input                 byt;
    input                 lsb;
    input [`PSA_PW_W-1:0] pw;
    begin
      if (hi)
        rd_pick = {8'h00, pw[23:16]}; // RQ4
      else if (byt)
        rd_pick = {8'h00, lsb ? pw[15:8] : pw[7:0]}; // RQ10
      else
        rd_pick = pw[15:0]; // RQ1
    end
  endfunction

  assign table_page_reg_out = table_page_reg_r;
  assign win_hit            = win_ea_in[`PSA_WIN_BIT];

  // Request decode: fetch first, then table, then window
  always @* begin
    state_nxt = ST_IDLE;
    addr_nxt  = prog_addr_out;
    mem_wr    = 1'b0;
    lane_en   = 3'b000;
    mem_wdata = {`PSA_PW_W{1'b0}};
    if (fetch_req_in) begin
      state_nxt = ST_FETCH;
      addr_nxt  = {1'b0, pc_in[22:1], 1'b0}; // RQ7
    end else if (table_read_instr_in || table_write_instr_in) begin
      state_nxt = ST_TBL;
      addr_nxt  = tbl_addr(table_page_reg_r, tbl_ea_in); // RQ3 RQ8 RQ9
      if (table_write_instr_in) begin
        mem_wr    = 1'b1;
        lane_en   = wr_lanes(tbl_hi_in, tbl_byte_in, tbl_ea_in[0]); // RQ4 RQ10
        mem_wdata = wr_word(tbl_hi_in, tbl_byte_in, tbl_wdata_in); // RQ1
      end
    end else if (win_rd_in && win_hit) begin
      state_nxt = ST_WIN;
      // Window EA<14:0> forms the low address bits, EA<14:1> the word index; alignment kept per RQ2
      addr_nxt  = {1'b0, win_page_r, win_ea_in[14:0]}; // RQ2 RQ3
    end
  end

  // Array indexed by word address, bits above array width ignored
  psa_mem u_mem (
    .clk_in     (clk_in),
    .addr_in    (addr_nxt[`PSA_MEM_AW:1]),
    .wr_in      (mem_wr),
    .lane_en_in (lane_en),
    .wdata_in   (mem_wdata),
    .rdata_out  (mem_rdata)
  );

  always @(posedge clk_in) begin
    if (rst_in) begin
      state_r            <= ST_IDLE;
      table_page_reg_r   <= `PSA_PAGE_RST;
      win_page_r         <= `PSA_WIN_PAGE_RST;
      prog_addr_out      <= {`PSA_PA_W{1'b0}};
      cfg_access_out     <= 1'b0;
      hi_r               <= 1'b0;
      byte_r             <= 1'b0;
      lane_r             <= 1'b0;
      win_wr_blocked_out <= 1'b0;
    end else begin
      state_r            <= state_nxt;
      prog_addr_out      <= addr_nxt;
      cfg_access_out     <= (state_nxt == ST_TBL) && table_page_reg_r[7]; // RQ9
      hi_r               <= tbl_hi_in;
      byte_r             <= tbl_byte_in;
      lane_r             <= tbl_ea_in[0];
      // Writes into the window never reach the array
      win_wr_blocked_out <= win_wr_in && win_hit; // RQ5
      if (page_wr_in)
        table_page_reg_r <= page_wdata_in;
      if (win_page_wr_in)
        win_page_r <= win_page_wdata_in;
    end
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      fetch_valid_out <= 1'b0;
      fetch_instr_out <= {`PSA_PW_W{1'b0}};
      tbl_valid_out   <= 1'b0;
      tbl_rdata_out   <= {`PSA_DW_W{1'b0}};
      win_valid_out   <= 1'b0;
      win_rdata_out   <= {`PSA_DW_W{1'b0}};
    end else begin
      fetch_valid_out <= 1'b0;
      tbl_valid_out   <= 1'b0;
      win_valid_out   <= 1'b0;
      case (state_r)
        ST_FETCH: begin
          fetch_valid_out <= 1'b1;
          fetch_instr_out <= mem_rdata;
        end
        ST_TBL: begin
          tbl_valid_out <= 1'b1;
          tbl_rdata_out <= rd_pick(hi_r, byte_r, lane_r, mem_rdata); // RQ4 RQ10
        end
        ST_WIN: begin
          win_valid_out <= 1'b1;
          win_rdata_out <= mem_rdata[15:0]; // RQ6
        end
        ST_IDLE: begin
          fetch_valid_out <= 1'b0;
        end
        default: begin
          fetch_valid_out <= 1'b0;
        end
      endcase
    end
  end
endmodule // psa_top

// ### tb/psa_chk_sva.sv
`timescale 1ns/1ps
module psa_chk (
  input logic        clk_in, rst_in, fetch_req_in, table_read_instr_in, table_write_instr_in, page_wr_in,
  input logic        win_rd_in, win_wr_in, fetch_valid_out, tbl_valid_out, win_valid_out, win_wr_blocked_out,
  input logic        cfg_access_out,
  input logic [22:0] pc_in,
  input logic [15:0] tbl_ea_in, win_ea_in,
  input logic [7:0]  table_page_reg_out,
  input logic [23:0] prog_addr_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire        tb  = (table_read_instr_in | table_write_instr_in) & !fetch_req_in;
  wire        wn  = win_ea_in[15] & !fetch_req_in & !table_read_instr_in & !table_write_instr_in;
  wire [21:0] pcw = pc_in[22:1];
  wire        pg7 = table_page_reg_out[7];
  property p_fa; fetch_req_in |=> prog_addr_out == {1'b0, $past(pcw), 1'b0}; endproperty
  a_fa: assert property (p_fa) else $error("fetch address");
  property p_ta; tb & !page_wr_in |=> prog_addr_out == {$past(table_page_reg_out), $past(tbl_ea_in)}; endproperty
  a_ta: assert property (p_ta) else $error("table address");
  property p_cf; tb & !page_wr_in |=> cfg_access_out == $past(pg7); endproperty
  a_cf: assert property (p_cf) else $error("config select");
  property p_fv; fetch_req_in & !$past(fetch_req_in) |=> !fetch_valid_out ##1 fetch_valid_out; endproperty
  a_fv: assert property (p_fv) else $error("fetch answer");
  property p_tv; tb |=> ##1 tbl_valid_out; endproperty
  a_tv: assert property (p_tv) else $error("table answer");
  property p_wb; win_wr_in & !win_rd_in & wn |=> win_wr_blocked_out; endproperty
  a_wb: assert property (p_wb) else $error("window write not blocked");
  property p_wv; win_rd_in & wn |=> ##1 win_valid_out; endproperty
  a_wv: assert property (p_wv) else $error("window answer");
  property p_wi; !win_rd_in & !fetch_req_in & !tb |=> ##1 !win_valid_out; endproperty
  a_wi: assert property (p_wi) else $error("window answer unasked");
  c_fv: cover property (fetch_valid_out);
  c_cf: cover property (cfg_access_out ##1 tbl_valid_out);
  c_wb: cover property (win_wr_blocked_out);
endmodule // psa_chk
bind psa_top psa_chk u_chk (.*);

// ### tb/psa_ref.sv
`timescale 1ns/1ps
// Core-side shadow of the program word array
module psa_ref;
  logic [23:0] mem [0:1023];
  task automatic wr(input logic [15:0] ea, input logic hi, byt, input logic [15:0] d);
    if (hi) mem[ea[10:1]][23:16] = d[7:0];
    else if (!byt) mem[ea[10:1]][15:0] = d;
    else if (ea[0]) mem[ea[10:1]][15:8] = d[7:0];
    else mem[ea[10:1]][7:0] = d[7:0];
  endtask
endmodule // psa_ref

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk_in = 0, rst_in = 1, fetch_req_in = 0, table_read_instr_in = 0, table_write_instr_in = 0;
  logic tbl_hi_in = 0, tbl_byte_in = 0, page_wr_in = 0, win_rd_in = 0, win_wr_in = 0, win_page_wr_in = 0;
  logic [22:0] pc_in = 0;
  logic [15:0] tbl_ea_in = 0, tbl_wdata_in = 0, win_ea_in = 0, tbl_rdata_out, win_rdata_out;
  logic [7:0]  page_wdata_in = 0, win_page_wdata_in = 0, table_page_reg_out;
  logic [7:0]  pv = 0, wpv = 0;
  logic        fetch_valid_out, tbl_valid_out, win_valid_out, win_wr_blocked_out, cfg_access_out;
  logic [23:0] fetch_instr_out, prog_addr_out, m;
  logic [31:0] lfsr = 32'h4AFDC669;
  logic [47:0] q[$], e;
  int          num_errors = 0, checks = 0;
  psa_top uut (.*);
  psa_ref core ();
  always #25 clk_in = ~clk_in;
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cmp(input logic [23:0] g, x);
    checks++;
    if (g !== x) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic stop_test;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic tbl(input logic wr, hi, byt, input logic [15:0] ea, d);
    logic [23:0] w;
    @(negedge clk_in);
    {table_write_instr_in, table_read_instr_in, tbl_hi_in, tbl_byte_in, tbl_ea_in, tbl_wdata_in} = {wr, !wr, hi, byt, ea, d};
    w = core.mem[ea[10:1]];
    m = (wr || |pv) ? 24'h000000 : (hi || byt) ? 24'h0000FF : 24'h00FFFF;
    q.push_back({m, hi ? {16'h0000, w[23:16]} : byt ? {16'h0000, ea[0] ? w[15:8] : w[7:0]} : w});
    if (wr) core.wr(ea, hi, byt, d);
    @(negedge clk_in);
    {table_write_instr_in, table_read_instr_in} = 2'b00;
    cmp(prog_addr_out, {pv, ea});
    cmp(cfg_access_out, pv[7]);
  endtask
  task automatic acc(input logic [1:0] k, input logic [15:0] ea);
    @(negedge clk_in);
    {fetch_req_in, win_rd_in, win_wr_in} = {k == 2'h0, k == 2'h1, k == 2'h2};
    {pc_in, win_ea_in} = {7'h00, ea, 1'b1, ea[14:0]};
    if (k != 2'h2) q.push_back({k == 2'h0 ? 24'hFFFFFF : 24'h00FFFF, core.mem[ea[10:1]]});
    @(negedge clk_in);
    {fetch_req_in, win_rd_in, win_wr_in} = 3'b000;
    if (k == 2'h0) cmp(prog_addr_out, {8'h00, ea[15:1], 1'b0});
    if (k == 2'h1) cmp(prog_addr_out, {1'b0, wpv, ea[14:0]});
    if (k == 2'h2) cmp(win_wr_blocked_out, 24'h000001);
  endtask
  task automatic pg(input logic [7:0] v);
    @(negedge clk_in);
    {page_wr_in, page_wdata_in} = {1'b1, v};
    @(negedge clk_in);
    page_wr_in = 0;
    pv = v;
    cmp(table_page_reg_out, v);
  endtask
  always @(negedge clk_in) if (fetch_valid_out | tbl_valid_out | win_valid_out) begin
    e = q.pop_front();
    cmp(e[47:24] & (fetch_valid_out ? fetch_instr_out : {8'h00, tbl_valid_out ? tbl_rdata_out : win_rdata_out}),
        e[47:24] & e[23:0]);
  end
  initial begin
    #100000;
    num_errors++;
    stop_test;
  end
  initial begin
    repeat (8) @(negedge clk_in);
    rst_in = 0;
    cmp(table_page_reg_out, 24'h000000);
    for (int i = 0; i < 12; i++) begin
      lfsr = lfsr_next(lfsr);
      tbl(1, 0, 0, {5'h00, lfsr[10:0]}, lfsr[31:16]);
      tbl(1, 1, 1, {5'h00, lfsr[10:1], 1'b0}, lfsr[15:0]);
      tbl(1, 0, 1, {5'h00, lfsr[10:0]}, lfsr[27:12]);
      tbl(0, 0, 0, {5'h00, lfsr[10:0]}, 16'h0000);
      tbl(0, 0, 1, {5'h00, lfsr[10:0]}, 16'h0000);
      tbl(0, 1, 0, {5'h00, lfsr[10:1], 1'b0}, 16'h0000);
      acc(2'h2, {5'h00, lfsr[10:0]});
      acc(2'h1, {5'h00, lfsr[10:0]});
      acc(2'h0, {5'h00, lfsr[10:0]});
    end
    @(negedge clk_in);
    {win_page_wr_in, win_page_wdata_in} = {1'b1, 8'h03};
    wpv = 8'h03;
    @(negedge clk_in);
    win_page_wr_in = 0;
    acc(2'h1, {5'h00, lfsr[10:0]});
    pg(8'h80);
    tbl(0, 0, 0, 16'h1234, 16'h0000);
    pg(8'h41);
    tbl(0, 1, 0, 16'hFFFE, 16'h0000);
    repeat (4) @(negedge clk_in);
    cmp(q.size(), 24'h000000);
    stop_test;
  end
endmodule // testbench
